// ### rtl/rtc_control_prescaler.sv
// first control register of the rtc and the prescaler it steers
// assumes: the serial bus engine runs on clk_in and presents byte
// accesses on reg_*; oscillator and clock pin are asynchronous pins
`timescale 1ns/1ps
`include "rtc_ctrl_defines.svh"

module rtc_control_prescaler (
  input  wire logic                      clk_in,
  input  wire logic                      srst_in,
  input  wire logic                      ce_in,
  input  wire logic                      osc_clk_in,
  input  wire logic                      clock_output_pin_in,
  output logic                           clock_output_pin_out,
  output logic                           clock_output_pin_oe_n_out,
  input  wire rtc_ctrl_pkg::clock_output_pin_sel_e clock_output_pin_sel_in,
  input  wire logic                      reg_ptr_load_in,
  input  wire logic [3:0]                reg_ptr_in,
  input  wire logic                      reg_wr_in,
  input  wire logic [7:0]                reg_wdata_in,
  input  wire logic                      reg_rd_in,
  output logic [7:0]                     reg_rdata_out,
  output logic [3:0]                     reg_ptr_out,
  input  wire logic                      correction_cycle_in,
  output logic                           external_clock_test_sel_out,
  output logic                           freeze_out,
  output logic                           correction_irq_enable_out,
  output logic                           hour_mode_12_out,
  output logic                           load_a_out,
  output logic                           soft_reset_out,
  output logic                           second_tick_out,
  output logic                           correction_irq_out
);

  logic [7:0]                ctrl_reg;
  logic [3:0]                ptr_reg;
  logic [7:0]                rdata_reg;
  logic                      srst_pulse_reg;
  logic                      tick_out_reg;
  logic                      irq_reg;
  logic                      pin_out_reg;
  logic                      pin_oe_n_reg;
  logic [2:0]                osc_sync_reg;
  logic [2:0]                pin_sync_reg;
  logic                      step;
  logic                      pre_tick;
  logic [`RTC_PRE_WIDTH-1:0] pre_count;
  logic                      ctrl_wr;
  logic                      soft_cmd;
  logic                      external_clock_test_sel;
  logic                      freeze;
  logic                      clk_level;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  // bit 0 is the metastable stage; only bit 1 reads it
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      osc_sync_reg <= 3'h0;
      pin_sync_reg <= 3'h0;
    end else if (ce_in) begin
      osc_sync_reg <= {osc_sync_reg[1:0], osc_clk_in};
      pin_sync_reg <= {pin_sync_reg[1:0], clock_output_pin_in};
    end
  end

  assign external_clock_test_sel = ctrl_reg[`RTC_BIT_EXTERNAL_CLOCK_TEST_SEL];
  assign freeze   = ctrl_reg[`RTC_BIT_FREEZE];

  // source select: pin edges replace the oscillator in test mode
  assign step = external_clock_test_sel ? (pin_sync_reg[1] && !pin_sync_reg[2])
                         : (osc_sync_reg[1] && !osc_sync_reg[2]);

  // test entry is not aligned to the chain; state is whatever it was
  rtc_prescaler u_prescaler (
    .clk_in    (clk_in),
    .srst_in   (srst_in),
    .ce_in     (ce_in),
    .step_in   (step),
    .test_in   (external_clock_test_sel),
    .freeze_in (freeze),
    .count_out (pre_count),
    .tick_out  (pre_tick)
  );

  // ----------------------------------------------------------------
  // register access
  // ----------------------------------------------------------------
  assign ctrl_wr  = reg_wr_in && (ptr_reg == `RTC_CTRL_ONE_ADDR);
  assign soft_cmd = ctrl_wr && (reg_wdata_in == `RTC_SOFT_RESET_CMD);

  // control bits; unused bits and the reset bit never stored
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      ctrl_reg <= `RTC_CTRL_ONE_RESET;
    end else if (ce_in) begin
      if (soft_cmd) begin
        ctrl_reg <= `RTC_CTRL_ONE_RESET;
      end else if (ctrl_wr) begin
        ctrl_reg <= reg_wdata_in & `RTC_CTRL_ONE_WMASK;
      end
    end
  end

  // pointer auto-increments and wraps after the last register
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      ptr_reg <= 4'h0;
    end else if (ce_in) begin
      if (soft_cmd) begin
        ptr_reg <= `RTC_CTRL_ONE_ADDR;
      end else if (reg_ptr_load_in) begin
        ptr_reg <= reg_ptr_in;
      end else if (reg_wr_in || reg_rd_in) begin
        if (ptr_reg >= `RTC_LAST_ADDR) begin
          ptr_reg <= 4'h0;
        end else begin
          ptr_reg <= ptr_reg + 4'h1;
        end
      end
    end
  end

  // read data; other addresses belong to neighbouring blocks
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      rdata_reg <= 8'h00;
    end else if (ce_in && reg_rd_in) begin
      if (ptr_reg == `RTC_CTRL_ONE_ADDR) begin
        rdata_reg <= ctrl_reg & `RTC_CTRL_ONE_WMASK;
      end else begin
        rdata_reg <= 8'h00;
      end
    end
  end

  // one-cycle reset strobe for the other registers of the device
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      srst_pulse_reg <= 1'b0;
    end else if (ce_in) begin
      srst_pulse_reg <= soft_cmd;
    end
  end

  // ----------------------------------------------------------------
  // time base and events
  // ----------------------------------------------------------------
  // gating on freeze too keeps counters steady while software writes
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      tick_out_reg <= 1'b0;
      irq_reg      <= 1'b0;
    end else if (ce_in) begin
      tick_out_reg <= pre_tick && !freeze;
      irq_reg      <= correction_cycle_in && ctrl_reg[`RTC_BIT_CIE];
    end
  end

  // frequency mux; frozen, only 8 kHz and above keep running
  always_comb begin
    clk_level = 1'b0;
    case (clock_output_pin_sel_in)
      rtc_ctrl_pkg::CLOCK_OUTPUT_PIN_32K: clk_level = osc_sync_reg[1];
      rtc_ctrl_pkg::CLOCK_OUTPUT_PIN_16K: clk_level = pre_count[0];
      rtc_ctrl_pkg::CLOCK_OUTPUT_PIN_8K:  clk_level = pre_count[1];
      rtc_ctrl_pkg::CLOCK_OUTPUT_PIN_4K:  clk_level = pre_count[2] && !freeze;
      rtc_ctrl_pkg::CLOCK_OUTPUT_PIN_2K:  clk_level = pre_count[3] && !freeze;
      rtc_ctrl_pkg::CLOCK_OUTPUT_PIN_1K:  clk_level = pre_count[4] && !freeze;
      rtc_ctrl_pkg::CLOCK_OUTPUT_PIN_1HZ: clk_level = pre_count[14] && !freeze;
      default:                  clk_level = 1'b0;
    endcase
  end

  // pin driver; in test mode the pin is released to act as input
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      pin_out_reg  <= 1'b0;
      pin_oe_n_reg <= 1'b0;
    end else if (ce_in) begin
      pin_out_reg  <= clk_level && !external_clock_test_sel;
      pin_oe_n_reg <= external_clock_test_sel;
    end
  end

  assign clock_output_pin_out        = pin_out_reg;
  assign clock_output_pin_oe_n_out   = pin_oe_n_reg;
  assign reg_rdata_out               = rdata_reg;
  assign reg_ptr_out                 = ptr_reg;
  assign external_clock_test_sel_out = ctrl_reg[`RTC_BIT_EXTERNAL_CLOCK_TEST_SEL];
  assign freeze_out                  = ctrl_reg[`RTC_BIT_FREEZE];
  assign correction_irq_enable_out   = ctrl_reg[`RTC_BIT_CIE];
  assign hour_mode_12_out            = ctrl_reg[`RTC_BIT_HOUR12];
  assign load_a_out                  = ctrl_reg[`RTC_BIT_LOAD_A];
  assign soft_reset_out              = srst_pulse_reg;
  assign second_tick_out             = tick_out_reg;
  assign correction_irq_out          = irq_reg;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (srst_in);

  a_soft_reset_cmd: assert property (
    ce_in && soft_cmd |=> ctrl_reg == `RTC_CTRL_ONE_RESET
      && ptr_reg == 4'h0 && soft_reset_out)
    else $error("soft reset command not honoured");

  a_reset_bit_zero: assert property (
    reg_rdata_out[`RTC_BIT_SOFT_RESET] == 1'b0)
    else $error("reset bit read back as one");

  a_unused_bits_zero: assert property (
    reg_rdata_out[6] == 1'b0 && reg_rdata_out[3] == 1'b0)
    else $error("unused bit read back as one");

  a_test_pin_input: assert property (
    ce_in && external_clock_test_sel |=> clock_output_pin_oe_n_out
      && !clock_output_pin_out)
    else $error("clock pin still driven in test mode");

  a_freeze_slow_off: assert property (
    ce_in && freeze && clock_output_pin_sel_in >= rtc_ctrl_pkg::CLOCK_OUTPUT_PIN_4K
      |=> !clock_output_pin_out)
    else $error("slow clock output while frozen");

  a_freeze_no_second: assert property (
    ce_in && freeze |=> !second_tick_out)
    else $error("second tick while frozen");

  a_ctrl_write_fields: assert property (
    ce_in && ctrl_wr && !soft_cmd |=>
      external_clock_test_sel_out == $past(reg_wdata_in[7])
      && freeze_out == $past(reg_wdata_in[5])
      && hour_mode_12_out == $past(reg_wdata_in[1])
      && load_a_out == $past(reg_wdata_in[0]))
    else $error("control write not stored");

  a_irq_gated: assert property (
    ce_in && correction_cycle_in |=>
      correction_irq_out == $past(ctrl_reg[`RTC_BIT_CIE]))
    else $error("correction pulse not gated by enable");

  c_soft_reset: cover property (soft_reset_out);
  c_test_mode:  cover property (external_clock_test_sel && clock_output_pin_oe_n_out);
  c_second:     cover property (second_tick_out && !external_clock_test_sel);

endmodule

// ### rtl/rtc_ctrl_defines.svh
// constants for the rtc control register and its 1 Hz prescaler
// assumes: included by bare name from files under rtl/
`ifndef RTC_CTRL_DEFINES_SVH
`define RTC_CTRL_DEFINES_SVH

// ----------------------------------------------------------------
// register map and layout
// ----------------------------------------------------------------
`define RTC_CTRL_ONE_ADDR   4'h0
`define RTC_LAST_ADDR       4'hA
`define RTC_CTRL_ONE_RESET  8'h00
`define RTC_SOFT_RESET_CMD  8'h58
`define RTC_BIT_EXTERNAL_CLOCK_TEST_SEL    7
`define RTC_BIT_FREEZE      5
`define RTC_BIT_SOFT_RESET  4
`define RTC_BIT_CIE         2
`define RTC_BIT_HOUR12      1
`define RTC_BIT_LOAD_A      0
`define RTC_CTRL_ONE_WMASK  8'hA7

// ----------------------------------------------------------------
// prescaler
// ----------------------------------------------------------------
`define RTC_PRE_WIDTH       15
`define RTC_TICK_BIT        14
`define RTC_NORMAL_STEP     15'h0001
`define RTC_TEST_STEP       15'h0200
`define RTC_NORMAL_PRESET   15'h7EFC
`define RTC_TEST_PRESET     15'h0000
`define RTC_TEST_LAST_IDLE  15'h3E00

`endif

// ### rtl/rtc_ctrl_pkg.sv
// types shared by the rtc control block
// assumes: compiled before the modules that use it
package rtc_ctrl_pkg;

  // clock output pin frequency choice, driven by the second control reg
  typedef enum logic [2:0] {
    CLOCK_OUTPUT_PIN_32K  = 3'b000,
    CLOCK_OUTPUT_PIN_16K  = 3'b001,
    CLOCK_OUTPUT_PIN_8K   = 3'b010,
    CLOCK_OUTPUT_PIN_4K   = 3'b011,
    CLOCK_OUTPUT_PIN_2K   = 3'b100,
    CLOCK_OUTPUT_PIN_1K   = 3'b101,
    CLOCK_OUTPUT_PIN_1HZ  = 3'b110,
    CLOCK_OUTPUT_PIN_OFF  = 3'b111
  } clock_output_pin_sel_e;

endpackage

// ### rtl/rtc_prescaler.sv
// 15-stage prescaler producing the one-second tick
// assumes: step_in is a one-cycle enable per source clock rising edge
`timescale 1ns/1ps
`include "rtc_ctrl_defines.svh"

module rtc_prescaler (
  input  wire logic                      clk_in,
  input  wire logic                      srst_in,
  input  wire logic                      ce_in,
  input  wire logic                      step_in,
  input  wire logic                      test_in,
  input  wire logic                      freeze_in,
  output logic [`RTC_PRE_WIDTH-1:0]      count_out,
  output logic                           tick_out
);

  logic [`RTC_PRE_WIDTH-1:0] cnt_reg;
  logic [`RTC_PRE_WIDTH-1:0] cnt_next;
  logic                      tick_reg;

  // a macro literal cannot be part-selected, so hold the preset here
  localparam logic [`RTC_PRE_WIDTH-1:0] normal_preset = `RTC_NORMAL_PRESET;

  // ----------------------------------------------------------------
  // next count
  // ----------------------------------------------------------------
  // test mode feeds the top six stages directly, so 64 steps wrap
  always_comb begin
    cnt_next = cnt_reg;
    if (freeze_in && test_in) begin
      cnt_next = `RTC_TEST_PRESET;
    end else if (freeze_in) begin
      // upper stages held at the preset, lowest two keep running
      cnt_next = {normal_preset[`RTC_PRE_WIDTH-1:2],
                  cnt_reg[1:0] + {1'b0, step_in}};
    end else if (step_in && test_in) begin
      cnt_next = cnt_reg + `RTC_TEST_STEP;
    end else if (step_in) begin
      cnt_next = cnt_reg + `RTC_NORMAL_STEP;
    end
  end

  // count state; the preset sets the release-to-first-tick delay
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      cnt_reg <= '0;
    end else if (ce_in) begin
      cnt_reg <= cnt_next;
    end
  end

  // tick on the 0 to 1 transition of the top stage
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      tick_reg <= 1'b0;
    end else if (ce_in) begin
      tick_reg <= cnt_next[`RTC_TICK_BIT] && !cnt_reg[`RTC_TICK_BIT];
    end
  end

  assign count_out = cnt_reg;
  assign tick_out  = tick_reg;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (srst_in);

  a_test_freeze_zero: assert property (
    ce_in && freeze_in && test_in |=> cnt_reg == `RTC_TEST_PRESET)
    else $error("test-mode freeze did not zero the prescaler");

  a_first_tick_32: assert property (
    ce_in && test_in && !freeze_in && step_in
      && cnt_reg == `RTC_TEST_LAST_IDLE |=> tick_reg)
    else $error("no tick on the 32nd edge after freeze");

  a_low_stages_run: assert property (
    ce_in && freeze_in && !test_in && step_in
      |=> cnt_reg[1:0] == $past(cnt_reg[1:0]) + 2'd1)
    else $error("low stages stopped during freeze");

  a_freeze_no_tick: assert property (
    ce_in && freeze_in ##1 ce_in && freeze_in |=> !tick_reg)
    else $error("tick produced while frozen");

  c_test_tick: cover property (test_in && tick_reg);

endmodule

// ### dv/rtc_host_model.sv
// host-side model: register bus byte accesses and the test clock pin
// assumes: clk_in is the device clock; drives change on falling edges
`timescale 1ns/1ps
module rtc_host_model (
  input  wire logic       clk_in,
  input  wire logic [7:0] rdata_in,
  output logic            ptr_load_out,
  output logic [3:0]      ptr_out,
  output logic            wr_out,
  output logic [7:0]      wdata_out,
  output logic            rd_out,
  output logic            pin_out
);
  // ----------------------------------------------------------------
  // idle levels
  // ----------------------------------------------------------------
  initial begin
    ptr_load_out = 1'b0;
    ptr_out      = 4'h0;
    wr_out       = 1'b0;
    wdata_out    = 8'h00;
    rd_out       = 1'b0;
    pin_out      = 1'b0;
  end

  // ----------------------------------------------------------------
  // one byte: pointer load, then a single write or read strobe
  // ----------------------------------------------------------------
  // soft reset is sent as the exact byte, nothing else
  task automatic access(input logic [3:0] a, input logic w,
                        input logic [7:0] d, output logic [7:0] q);
    @(negedge clk_in);
    ptr_load_out = 1'b1;
    ptr_out      = a;
    @(negedge clk_in);
    ptr_load_out = 1'b0;
    wr_out       = w;
    rd_out       = !w;
    wdata_out    = d;
    @(negedge clk_in);
    wr_out = 1'b0;
    rd_out = 1'b0;
    // read data holds until the next read, so one spare cycle is safe
    @(negedge clk_in);
    q = rdata_in;
  endtask

  // ----------------------------------------------------------------
  // test clock pulses, 3 cycles high and 3 low (wider than minimum)
  // ----------------------------------------------------------------
  task automatic pulses(input int n);
    repeat (n) begin
      pin_out = 1'b1;
      repeat (3) @(negedge clk_in);
      pin_out = 1'b0;
      repeat (3) @(negedge clk_in);
    end
  endtask
endmodule

// ### dv/tb_top.sv
// self-checking bench for the rtc control register and prescaler
// assumes: host model in rtc_host_model.sv; design files under rtl/
`timescale 1ns/1ps
module tb_top;
  logic clk_in, srst_in, osc, corr, tick, irq, sr, pin_o, oe_n;
  logic [7:0] rdata, wdata, q, rnd;
  logic [3:0] ptr_o, ptr_h;
  logic ld, wr, rd, host_pin, pin_lvl, ext, frz, correction_irq_enable, h12, loada, ce;
  rtc_ctrl_pkg::clock_output_pin_sel_e sel;
  int error_cnt, n_compared, cyc, tick_cnt, irq_cnt, sr_cnt, hi;
  int m_ctrl, m_ptr, seed;

  // pin level: device drives unless its enable is released
  assign pin_lvl = oe_n ? host_pin : pin_o;

  rtc_control_prescaler uut (
    .clk_in                      (clk_in),
    .srst_in                     (srst_in),
    .ce_in                       (ce),
    .osc_clk_in                  (osc),
    .clock_output_pin_in         (pin_lvl),
    .clock_output_pin_out        (pin_o),
    .clock_output_pin_oe_n_out   (oe_n),
    .clock_output_pin_sel_in               (sel),
    .reg_ptr_load_in             (ld),
    .reg_ptr_in                  (ptr_h),
    .reg_wr_in                   (wr),
    .reg_wdata_in                (wdata),
    .reg_rd_in                   (rd),
    .reg_rdata_out               (rdata),
    .reg_ptr_out                 (ptr_o),
    .correction_cycle_in         (corr),
    .external_clock_test_sel_out (ext),
    .freeze_out                  (frz),
    .correction_irq_enable_out   (correction_irq_enable),
    .hour_mode_12_out            (h12),
    .load_a_out                  (loada),
    .soft_reset_out              (sr),
    .second_tick_out             (tick),
    .correction_irq_out          (irq)
  );

  rtc_host_model host (
    .clk_in       (clk_in),
    .rdata_in     (rdata),
    .ptr_load_out (ld),
    .ptr_out      (ptr_h),
    .wr_out       (wr),
    .wdata_out    (wdata),
    .rd_out       (rd),
    .pin_out      (host_pin)
  );

  // ----------------------------------------------------------------
  // clock, fast stand-in oscillator, pulse counters, hang limit
  // ----------------------------------------------------------------
  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end
  // oscillator sped up so frozen behaviour shows in a few cycles
  initial begin
    osc = 1'b0;
    forever begin
      repeat (3) @(negedge clk_in);
      osc = ~osc;
    end
  end
  always @(posedge clk_in) begin
    cyc = cyc + 1;
    if (tick === 1'b1) tick_cnt = tick_cnt + 1;
    if (irq === 1'b1) irq_cnt = irq_cnt + 1;
    if (sr === 1'b1) sr_cnt = sr_cnt + 1;
    if (cyc == 20000) begin
      error_cnt = error_cnt + 1;
      final_report();
    end
  end

  // ----------------------------------------------------------------
  // compare, model-backed accesses, verdict
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
    n_compared = n_compared + 1;
    if (seen !== exp) begin
      error_cnt = error_cnt + 1;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // model: masked store, exact-byte reset, pointer wrap after 0Ah
  task automatic access(input logic [3:0] a, input logic w,
                        input logic [7:0] d);
    host.access(a, w, d, q);
    if (w && a == 4'h0 && d == 8'h58) begin
      m_ctrl = 0;
      m_ptr  = 0;
    end else begin
      if (w && a == 4'h0) m_ctrl = d & 8'hA7;
      m_ptr = (a == 4'hA) ? 0 : a + 1;
    end
    if (!w) check("rdata", q, (a == 4'h0) ? m_ctrl[7:0] : 8'h00);
    check("ptr", {4'h0, ptr_o}, m_ptr[7:0]);
    check("fields", {ext, 1'b0, frz, 2'b00, correction_irq_enable, h12, loada},
          m_ctrl[7:0]);
  endtask

  task automatic settle(input int n);
    repeat (n) @(negedge clk_in);
  endtask

  task automatic final_report();
    $display("compared %0d errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {error_cnt, n_compared, cyc, tick_cnt, irq_cnt, sr_cnt} = 0;
    {m_ctrl, m_ptr} = 0;
    seed    = 62;
    srst_in = 1'b1;
    ce      = 1'b1;
    corr    = 1'b0;
    sel     = rtc_ctrl_pkg::CLOCK_OUTPUT_PIN_OFF;
    repeat (16) @(negedge clk_in);
    srst_in = 1'b0;
    check("oe_n", {7'h0, oe_n}, 8'h00);
    access(4'h0, 1'b0, 8'h00);
    $display("test reset done");
    // random bytes: bits 6,4,3 never stick, others do
    repeat (8) begin
      rnd = 8'($random(seed));
      if (rnd == 8'h58) rnd = 8'h59;
      access(4'h0, 1'b1, rnd);
      access(4'h0, 1'b0, 8'h00);
      access(4'hA, 1'b0, 8'h00);
    end
    // enable low: a whole write, pointer load included, leaves no trace
    ce = 1'b0;
    host.access(4'h0, 1'b1, ~m_ctrl[7:0] & 8'hA7, q);
    ce = 1'b1;
    check("ce ptr", {4'h0, ptr_o}, m_ptr[7:0]);
    check("ce fields", {ext, 1'b0, frz, 2'b00, correction_irq_enable, h12, loada},
          m_ctrl[7:0]);
    $display("test fields done");
    access(4'h0, 1'b1, 8'hB7);
    check("sr_cnt", sr_cnt[7:0], 8'h00);
    access(4'h0, 1'b1, 8'h58);
    check("sr_cnt", sr_cnt[7:0], 8'h01);
    $display("test soft reset done");
    // correction pulses pass only while enabled
    for (int en = 1; en >= 0; en--) begin
      access(4'h0, 1'b1, en ? 8'h04 : 8'h00);
      irq_cnt = 0;
      hi = 0;
      repeat (8) begin
        rnd = 8'($random(seed));
        corr = rnd[0];
        if (rnd[0] && en != 0) hi = hi + 1;
        settle(1);
        corr = 1'b0;
        settle(2);
      end
      settle(3);
      check("irq_cnt", irq_cnt[7:0], hi[7:0]);
    end
    $display("test correction done");
    // frozen: 4 kHz and slower quiet, 16 kHz and 8 kHz still toggle
    access(4'h0, 1'b1, 8'h20);
    for (int s = 1; s <= 6; s++) begin
      sel = rtc_ctrl_pkg::clock_output_pin_sel_e'(s);
      settle(4);
      hi = 0;
      repeat (40) begin
        settle(1);
        if (pin_o === 1'b1) hi = hi + 1;
      end
      check("slow pin", {7'h0, hi > 0}, {7'h0, s < 3});
    end
    check("tick_cnt", tick_cnt[7:0], 8'h00);
    $display("test freeze done");
    // test mode: enter, freeze, release, count pin edges to each tick
    access(4'h0, 1'b1, 8'h80);
    access(4'h0, 1'b1, 8'hA0);
    check("oe_n", {7'h0, oe_n}, 8'h01);
    access(4'h0, 1'b1, 8'h80);
    tick_cnt = 0;
    host.pulses(31);
    settle(10);
    check("tick 31", tick_cnt[7:0], 8'h00);
    host.pulses(1);
    settle(10);
    check("tick 32", tick_cnt[7:0], 8'h01);
    host.pulses(63);
    settle(10);
    check("tick 95", tick_cnt[7:0], 8'h01);
    host.pulses(1);
    settle(10);
    check("tick 96", tick_cnt[7:0], 8'h02);
    access(4'h0, 1'b1, 8'hA0);
    host.pulses(40);
    access(4'h0, 1'b1, 8'h80);
    host.pulses(32);
    settle(10);
    check("tick refreeze", tick_cnt[7:0], 8'h03);
    $display("test external clock done");
    final_report();
  end
endmodule
